// File: verilog/rdc_defs.svh
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH
`define RDC_WORD_W 16
`define RDC_BYTE_W 8
`define RDC_FIFO_DEPTH 32
`define RDC_PIN_W 14
`define RDC_PIN_CS 13
`define RDC_PIN_RD 12
`define RDC_PIN_WR 11
`define RDC_PIN_SEL 10
`define RDC_PIN_MHI 9
`define RDC_PIN_MLO 8
`define RDC_PIN_RST 14'h3800
`define RDC_CNT_W 4
`define RDC_MODE_POS 2'h0
`define RDC_MODE_VEL 2'h1
`define RDC_MODE_CFG 2'h3
`endif

// File: verilog/rdc_pkg.sv
package rdc_pkg;
  // Operating modes chosen by the mode pins
  typedef enum logic [1:0] {
    MODE_POSITION, MODE_VELOCITY, MODE_RESERVED, MODE_CONFIG
  } rdc_mode_type;
  // Fault conditions from the converter core
  typedef struct packed {
    logic sinOver;
    logic cosOver;
    logic ampMismatch;
    logic trackLost;
  } rdc_fault_type;
  // Encoder emulation outputs
  typedef struct packed {
    logic quadA;
    logic quadB;
    logic marker;
    logic dir;
  } rdc_enc_type;
endpackage : rdc_pkg

// File: verilog/rdc_host_pins.sv
`timescale 1ns/1ns
`include "rdc_defs.svh"

// Sample FIFO between converter core and host port
module rdc_fifo #(
  parameter int WIDTH = `RDC_WORD_W,
  parameter int DEPTH = `RDC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Sample storage
  logic [AW:0] wrPtr_reg; // Write pointer with wrap bit
  logic [AW:0] rdPtr_reg; // Read pointer with wrap bit
  logic full;
  // Full when pointers differ only in wrap bit
  assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign inReady = !full;
  assign outValid = (wrPtr_reg != rdPtr_reg);
  assign outData = mem[rdPtr_reg[AW-1:0]];
  // Store on accepted push
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end
  // Pointer update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (outReady && outValid) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule : rdc_fifo

// Host pin logic of the converter
module rdc_host_pins (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [15:0] sampleData,
  input wire logic [15:0] velocityData,
  input wire logic [15:0] angleNow,
  input wire logic inputsValid,
  input wire rdc_pkg::rdc_fault_type faults,
  output rdc_pkg::rdc_mode_type activeMode,
  output logic hostWriteValid,
  output logic [7:0] hostWriteData,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeOrFrameSyncN,
  input wire logic portTypeSelect,
  input wire logic modeSelHi,
  input wire logic modeSelLo,
  input wire logic bit13OrShiftClockIn,
  output logic bit13OrShiftClockOut,
  output logic bit13OrShiftClockOe,
  output logic serialOutLineOut,
  output logic serialOutLineOe,
  input wire logic serialInLineIn,
  output logic serialInLineOut,
  output logic serialInLineOe,
  output logic [3:0] upperDataLinesOut,
  output logic upperDataLinesOe,
  output logic dataLineEightOut,
  output logic dataLineEightOe,
  input wire logic [7:0] lowByteLinesIn,
  output logic [7:0] lowByteLinesOut,
  output logic lowByteLinesOe,
  output logic quadA,
  output logic quadB,
  output logic revMarker,
  output logic rotationDir,
  output logic trackingFaultN,
  output logic signalDegradedN
);
  logic [`RDC_PIN_W-1:0] pinS1_reg; // Sync stage one
  logic [`RDC_PIN_W-1:0] pinS2_reg; // Sync stage two
  logic [`RDC_PIN_W-1:0] pinS3_reg; // Sync stage three
  logic [`RDC_PIN_W-1:0] pinF_reg; // Agreed pin levels
  logic csAct; // Chip selected
  logic parMode; // Parallel port chosen
  logic readAct; // Parallel read in progress
  logic writeAct; // Parallel write in progress
  logic frameAct; // Serial frame in progress
  logic readPrev_reg; // Read level last cycle
  logic writePrev_reg; // Write level last cycle
  logic framePrev_reg; // Frame level last cycle
  rdc_pkg::rdc_mode_type mode_reg; // Decoded mode
  rdc_pkg::rdc_mode_type mode_next;
  logic fifoValid; // FIFO head present
  logic [15:0] fifoData; // FIFO head word
  logic fifoPop; // Consume head
  logic [15:0] outWord_reg; // Word presented to host
  logic [15:0] wordSel; // Next word while idle
  logic [7:0] wrData_reg; // Last byte from host
  logic wrValid_reg; // Byte strobe
  logic [`RDC_CNT_W-1:0] bitCnt_reg; // Serial bit index
  logic [15:0] outShift_reg; // Serial output shifter
  logic [7:0] inShift_reg; // Serial input shifter
  logic [15:0] prevAngle_reg; // Angle at last valid cycle
  logic [15:0] angleDiff; // Angle change
  rdc_pkg::rdc_enc_type enc_reg; // Encoder outputs
  logic trackN_reg; // Tracking fault level
  logic degradedN_reg; // Degradation level
  // Keep an agreed bit, or take stage three where stages agree
  function automatic logic [`RDC_PIN_W-1:0] agreeUpd(
    input logic [`RDC_PIN_W-1:0] cur,
    input logic [`RDC_PIN_W-1:0] s2,
    input logic [`RDC_PIN_W-1:0] s3
  );
    agreeUpd = (s3 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction : agreeUpd

  // Three-stage pin synchroniser with agreement filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1_reg <= `RDC_PIN_RST;
      pinS2_reg <= `RDC_PIN_RST;
      pinS3_reg <= `RDC_PIN_RST;
      pinF_reg <= `RDC_PIN_RST;
    end else begin
      pinS1_reg <= {chipSelectN, readStrobeN, writeOrFrameSyncN,
                    portTypeSelect, modeSelHi, modeSelLo, lowByteLinesIn};
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinF_reg <= agreeUpd(pinF_reg, pinS2_reg, pinS3_reg);
    end
  end

  // Strobe qualification
  assign csAct = !pinF_reg[`RDC_PIN_CS];
  assign parMode = pinF_reg[`RDC_PIN_SEL];
  assign readAct = parMode && csAct && !pinF_reg[`RDC_PIN_RD];
  assign writeAct = parMode && csAct && !pinF_reg[`RDC_PIN_WR];
  assign frameAct = !parMode && csAct && !pinF_reg[`RDC_PIN_WR];

  // Joint decode of both mode pins
  always_comb begin
    unique case (pinF_reg[`RDC_PIN_MHI:`RDC_PIN_MLO])
      `RDC_MODE_POS: mode_next = rdc_pkg::MODE_POSITION;
      `RDC_MODE_VEL: mode_next = rdc_pkg::MODE_VELOCITY;
      `RDC_MODE_CFG: mode_next = rdc_pkg::MODE_CONFIG;
      default: mode_next = rdc_pkg::MODE_RESERVED;
    endcase
  end

  // Mode register and strobe history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= rdc_pkg::MODE_POSITION;
      readPrev_reg <= 1'b0;
      writePrev_reg <= 1'b0;
      framePrev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      readPrev_reg <= readAct;
      writePrev_reg <= writeAct;
      framePrev_reg <= frameAct;
    end
  end
  assign activeMode = mode_reg;

  // Samples queue up here; core stalls when full
  rdc_fifo #(.WIDTH(`RDC_WORD_W), .DEPTH(`RDC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // Pop at start of a position read or frame
  assign fifoPop = fifoValid && (mode_reg == rdc_pkg::MODE_POSITION) &&
                   ((readAct && !readPrev_reg) || (frameAct && !framePrev_reg));
  // Idle word: velocity, FIFO head, or last word kept
  assign wordSel = (mode_reg == rdc_pkg::MODE_VELOCITY) ? velocityData :
                   (fifoValid ? fifoData : outWord_reg);

  // Output word frozen during any parallel read or serial frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outWord_reg <= '0;
    end else if (!readAct && !frameAct) begin
      outWord_reg <= wordSel;
    end
  end

  // Byte from host at end of a write or serial frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrData_reg <= '0;
      wrValid_reg <= 1'b0;
    end else begin
      wrValid_reg <= 1'b0;
      if (!writeAct && writePrev_reg) begin
        wrData_reg <= pinF_reg[7:0];
        wrValid_reg <= (mode_reg == rdc_pkg::MODE_CONFIG);
      end else if (!frameAct && framePrev_reg) begin
        // Shift clock is quiet after the frame, shifter is stable
        wrData_reg <= inShift_reg;
        wrValid_reg <= (mode_reg == rdc_pkg::MODE_CONFIG);
      end
    end
  end
  assign hostWriteData = wrData_reg;
  assign hostWriteValid = wrValid_reg;

  // Parallel pin drive; all enables need chip select
  assign bit13OrShiftClockOut = outWord_reg[13];
  assign bit13OrShiftClockOe = readAct;
  assign upperDataLinesOut = outWord_reg[12:9];
  assign upperDataLinesOe = readAct;
  assign dataLineEightOut = outWord_reg[8];
  assign dataLineEightOe = readAct;
  assign lowByteLinesOut = outWord_reg[7:0];
  assign lowByteLinesOe = readAct;
  assign serialInLineOut = outWord_reg[14];
  assign serialInLineOe = readAct;
  // Bit 15 in parallel, serial data out in serial
  assign serialOutLineOut = parMode ? outWord_reg[15] : outShift_reg[15];
  assign serialOutLineOe = readAct || frameAct;

  // Shift clock domain: frame sync travels with the clock
  // Word is held frozen by the main domain during frames
  always_ff @(posedge bit13OrShiftClockIn or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg <= '0;
      outShift_reg <= '0;
    end else if (!writeOrFrameSyncN) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
      if (bitCnt_reg == '0) begin
        outShift_reg <= outWord_reg;
      end else begin
        outShift_reg <= {outShift_reg[14:0], 1'b0};
      end
    end
  end

  // Input capture on falling shift clock
  always_ff @(negedge bit13OrShiftClockIn or negedge reset_n) begin
    if (!reset_n) begin
      inShift_reg <= '0;
    end else if (!writeOrFrameSyncN) begin
      inShift_reg <= {inShift_reg[6:0], serialInLineIn};
    end
  end

  // Encoder emulation, held while inputs invalid
  assign angleDiff = angleNow - prevAngle_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevAngle_reg <= '0;
      enc_reg <= '0;
    end else if (inputsValid) begin
      prevAngle_reg <= angleNow;
      enc_reg.quadA <= angleNow[1];
      enc_reg.quadB <= angleNow[1] ^ angleNow[0];
      enc_reg.marker <= (angleNow == '0);
      if (angleDiff != '0) begin
        enc_reg.dir <= !angleDiff[15];
      end
    end
  end
  assign quadA = enc_reg.quadA;
  assign quadB = enc_reg.quadB;
  assign revMarker = enc_reg.marker;
  assign rotationDir = enc_reg.dir;

  // Fault pins follow present conditions, not latched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trackN_reg <= 1'b1;
      degradedN_reg <= 1'b1;
    end else begin
      trackN_reg <= !faults.trackLost;
      degradedN_reg <= !(faults.sinOver || faults.cosOver ||
                         faults.ampMismatch);
    end
  end
  assign trackingFaultN = trackN_reg;
  assign signalDegradedN = degradedN_reg;

  // Checks
  chk_bit13_serial: assert property (@(posedge clk) disable iff (!reset_n)
    !parMode |-> !bit13OrShiftClockOe)
    else $error("bit13 driven in serial mode");
  chk_upper_read: assert property (@(posedge clk) disable iff (!reset_n)
    upperDataLinesOe |-> (!pinF_reg[`RDC_PIN_CS] && !pinF_reg[`RDC_PIN_RD]))
    else $error("upper lines driven without read");
  chk_low_write: assert property (@(posedge clk) disable iff (!reset_n)
    (writePrev_reg && !writeAct) |=> (wrData_reg == $past(pinF_reg[7:0])))
    else $error("written byte not captured");
  chk_quad_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !inputsValid |=> ($stable(quadA) && $stable(quadB)))
    else $error("quadrature moved on invalid inputs");
  chk_marker_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (inputsValid && angleNow == '0) |=> revMarker)
    else $error("marker missed at zero angle");
  chk_dir_up: assert property (@(posedge clk) disable iff (!reset_n)
    (inputsValid && angleDiff != '0 && !angleDiff[15]) |=> rotationDir)
    else $error("direction low while increasing");
  chk_lot_follow: assert property (@(posedge clk) disable iff (!reset_n)
    faults.trackLost ##1 !faults.trackLost |-> !trackingFaultN ##1 trackingFaultN)
    else $error("tracking fault not following");
  chk_dos_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (faults.sinOver || faults.cosOver || faults.ampMismatch) |=> !signalDegradedN)
    else $error("degradation not shown");
  chk_mode_config: assert property (@(posedge clk) disable iff (!reset_n)
    (pinF_reg[`RDC_PIN_MHI:`RDC_PIN_MLO] == `RDC_MODE_CFG) |=>
    (activeMode == rdc_pkg::MODE_CONFIG))
    else $error("mode decode wrong");
  chk_shift_load: assert property (@(posedge bit13OrShiftClockIn) disable iff (!reset_n)
    (!writeOrFrameSyncN && bitCnt_reg == '0) |=> (outShift_reg == $past(outWord_reg)))
    else $error("serial word not loaded");
  chk_shift_in: assert property (@(negedge bit13OrShiftClockIn) disable iff (!reset_n)
    !writeOrFrameSyncN |=> (inShift_reg[0] == $past(serialInLineIn)))
    else $error("serial input not captured");
  chk_idle_float: assert property (@(posedge clk) disable iff (!reset_n)
    pinF_reg[`RDC_PIN_CS] |-> !(lowByteLinesOe || upperDataLinesOe || serialOutLineOe ||
    bit13OrShiftClockOe || dataLineEightOe || serialInLineOe))
    else $error("pins driven while deselected");
endmodule : rdc_host_pins

// File: dv/rdc_host_model.sv
`timescale 1ns/1ns

// Host controller on the far side of the pins
module rdc_host_model (
  input wire logic clk,
  input wire logic [15:0] word,
  input wire logic oeAll,
  input wire logic oeAny,
  input wire logic serial_out_line,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic pts,
  output logic mHi,
  output logic mLo,
  output logic sclk,
  output logic serial_in_line,
  output logic [7:0] lowDrv
);
  // Idle pins; a released line shows a pattern, not the last value
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    pts = 1'b1;
    mHi = 1'b0;
    mLo = 1'b0;
    sclk = 1'b0;
    serial_in_line = 1'b0;
    lowDrv = 8'h5a;
  end

  // Port type and mode pins, then settle time
  task automatic set_mode(input logic p, input logic [1:0] m);
    @(posedge clk);
    pts <= p;
    mHi <= m[1];
    mLo <= m[0];
    repeat (6) @(posedge clk);
  endtask : set_mode

  // Parallel read: word taken while all enables stand
  task automatic par_read(output logic [15:0] w, output logic oe);
    int n;
    @(posedge clk);
    csN <= 1'b0;
    rdN <= 1'b0;
    n = 0;
    while (!oeAny && n < 20) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    w = word;
    oe = oeAll;
    repeat (5) @(posedge clk);
    rdN <= 1'b1;
    csN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : par_read

  // Parallel write: host drives the low byte under strobe
  task automatic par_write(input logic [7:0] b);
    @(posedge clk);
    csN <= 1'b0;
    wrN <= 1'b0;
    lowDrv <= b;
    repeat (6) @(posedge clk);
    wrN <= 1'b1;
    repeat (6) @(posedge clk);
    csN <= 1'b1;
    lowDrv <= ~b;
  endtask : par_write

  // Serial frame; shift clock runs only inside the frame
  task automatic ser_frame(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk);
    csN <= 1'b0;
    wrN <= 1'b0;
    repeat (6) @(posedge clk);
    #7;
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b1;
      serial_in_line <= tx[i];
      #40;
      rx[i] = serial_out_line;
      sclk <= 1'b0;
      #40;
    end
    serial_in_line <= ~tx[0];
    repeat (6) @(posedge clk);
    csN <= 1'b1;
    wrN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : ser_frame
endmodule : rdc_host_model

// File: dv/tb.sv
`timescale 1ns/1ns

module tb;
  logic clk, reset_n, sampleValid, sampleReady, inputsValid, hostWriteValid;
  logic [15:0] sampleData, velocityData, angleNow, w, e;
  rdc_pkg::rdc_fault_type faults;
  rdc_pkg::rdc_mode_type activeMode;
  logic [7:0] hostWriteData, lowOut, lowDrv, lowIn;
  logic csN, rdN, wrN, pts, mHi, mLo, sclk, serial_in_line, oe, dir;
  logic b13Out, b13Oe, sdoOut, sdoOe, sdiOut, sdiOe, d8Out, d8Oe, lowOe;
  logic [3:0] upOut;
  logic upOe, quadA, quadB, revMarker, rotationDir, trackingFaultN, signalDegradedN;
  logic [31:0] v;
  logic [15:0] a;
  int errors = 0, n_checks = 0, cyc = 0, pulses = 0, i;
  logic [15:0] q[$];
  // Pin views: composed word, enables and wire levels
  wire logic [15:0] word = {sdoOut, sdiOut, b13Out, upOut, d8Out, lowOut};
  wire logic [5:0] oeVec = {sdoOe, sdiOe, b13Oe, upOe, d8Oe, lowOe};
  wire logic b13In = b13Oe ? b13Out : sclk;
  wire logic sdiIn = sdiOe ? sdiOut : serial_in_line;
  assign lowIn = lowOe ? lowOut : lowDrv;

  // Main clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse counter and hang limit
  always @(negedge clk) pulses += hostWriteValid;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  rdc_host_model host (.clk(clk), .word(word), .oeAll(&oeVec), .oeAny(|oeVec), .serial_out_line(sdoOut),
    .csN(csN), .rdN(rdN), .wrN(wrN), .pts(pts), .mHi(mHi), .mLo(mLo), .sclk(sclk),
    .serial_in_line(serial_in_line), .lowDrv(lowDrv));

  rdc_host_pins DUT (.clk(clk), .reset_n(reset_n), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData), .velocityData(velocityData),
    .angleNow(angleNow), .inputsValid(inputsValid), .faults(faults),
    .activeMode(activeMode), .hostWriteValid(hostWriteValid), .hostWriteData(hostWriteData),
    .chipSelectN(csN), .readStrobeN(rdN), .writeOrFrameSyncN(wrN), .portTypeSelect(pts),
    .modeSelHi(mHi), .modeSelLo(mLo), .bit13OrShiftClockIn(b13In),
    .bit13OrShiftClockOut(b13Out), .bit13OrShiftClockOe(b13Oe), .serialOutLineOut(sdoOut),
    .serialOutLineOe(sdoOe), .serialInLineIn(sdiIn), .serialInLineOut(sdiOut),
    .serialInLineOe(sdiOe), .upperDataLinesOut(upOut), .upperDataLinesOe(upOe),
    .dataLineEightOut(d8Out), .dataLineEightOe(d8Oe), .lowByteLinesIn(lowIn),
    .lowByteLinesOut(lowOut), .lowByteLinesOe(lowOe), .quadA(quadA), .quadB(quadB),
    .revMarker(revMarker), .rotationDir(rotationDir), .trackingFaultN(trackingFaultN),
    .signalDegradedN(signalDegradedN));

  // Main sequence
  initial begin
    reset_n = 1'b0;
    sampleValid = 1'b0;
    sampleData = 16'h0;
    velocityData = 16'h0;
    angleNow = 16'h0;
    inputsValid = 1'b0;
    faults = '0;
    v = 32'hb544;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(oeVec), 16'h0);
    // Fill the sample buffer until it refuses
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      v = lfsr(v);
      sampleValid <= 1'b1;
      sampleData <= v[15:0];
      @(negedge clk);
      if (sampleReady !== 1'b1) break;
      q.push_back(v[15:0]);
    end
    @(posedge clk);
    sampleValid <= 1'b0;
    chk(16'(q.size()), 16'h20);
    // Drain by parallel reads; empty buffer repeats last word
    for (i = 0; i < 33; i++) begin
      host.par_read(w, oe);
      if (i < 32) e = q.pop_front();
      chk(w, e);
      chk(16'(oe), 16'h1);
      chk(16'(oeVec), 16'h0);
    end
    // Every mode code
    for (i = 0; i < 4; i++) begin
      host.set_mode(1'b1, i[1:0]);
      chk(16'(activeMode), 16'(i));
    end
    // Writes in config mode pulse, in position mode only capture
    for (i = 0; i < 2; i++) begin
      host.set_mode(1'b1, (i == 0) ? 2'h3 : 2'h0);
      v = lfsr(v);
      pulses = 0;
      host.par_write(v[7:0]);
      repeat (8) @(posedge clk);
      chk(16'(hostWriteData), 16'(v[7:0]));
      chk(16'(pulses), (i == 0) ? 16'h1 : 16'h0);
    end
    // Serial frame in velocity mode
    v = lfsr(v);
    velocityData <= v[31:16];
    host.set_mode(1'b0, 2'h1);
    host.ser_frame(v[15:0], w);
    repeat (8) @(posedge clk);
    chk(w, v[31:16]);
    chk(16'(hostWriteData), 16'(v[7:0]));
    // Encoder emulation over a rising then falling angle
    inputsValid <= 1'b1;
    dir = 1'b0;
    e = 16'h0;
    for (i = 0; i < 8; i++) begin
      a = (i < 4) ? 16'(i) : 16'(6 - i);
      if (i == 7) inputsValid <= 1'b0;
      else begin
        if (a > e) dir = 1'b1;
        else if (a < e) dir = 1'b0;
        e = a;
      end
      @(posedge clk);
      angleNow <= (i == 7) ? 16'h5 : a;
      repeat (5) @(posedge clk);
      chk(16'({quadA, quadB, revMarker, rotationDir}),
        16'({e[1], e[1] ^ e[0], e == 16'h0, dir}));
    end
    // Fault flags follow each present condition
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      faults <= (i < 4) ? 4'(1 << i) : 4'h0;
      repeat (5) @(posedge clk);
      chk(16'({trackingFaultN, signalDegradedN}),
        16'({!faults.trackLost, !(faults.sinOver | faults.cosOver | faults.ampMismatch)}));
    end
    end_sim();
  end
endmodule : tb
